// ---- mem_cmd_pkg.sv ----
// Constants, types and helpers of the memory command and status logic
package mem_cmd_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS     = 8'h00;
    localparam logic [7:0] OFS_COMMAND    = 8'h04;
    localparam logic [7:0] OFS_DIVIDER    = 8'h08;
    localparam logic [7:0] OFS_DATA       = 8'h0c;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_MASK   = 8'h14;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int BIT_CBEF    = 7;
    localparam int BIT_CCF     = 6;
    localparam int BIT_AERR    = 4;
    localparam int BIT_BLANK   = 2;
    localparam int BIT_DIV_SET = 7;
    localparam int DIV_W       = 7;
    localparam int INT_DONE    = 0;
    localparam int INT_AERR    = 1;
    localparam int INT_W       = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [DIV_W-1:0] RST_DIVIDER = 7'h00;
    localparam logic [INT_W-1:0] RST_INT     = 2'h0;
    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_BLANK_CHECK    = 8'h05;
    localparam logic [7:0] CMD_SINGLE_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_BURST_PROGRAM  = 8'h25;
    localparam logic [7:0] CMD_SECTOR_ERASE   = 8'h40;
    localparam logic [7:0] CMD_ARRAY_ERASE    = 8'h41;
    localparam logic [7:0] CMD_ERASE_ABORT    = 8'h47;
    // ----------------------------------------------------------------
    // Execution lengths in divided memory clock ticks
    // ----------------------------------------------------------------
    localparam int TMR_W = 16;
    localparam logic [TMR_W-1:0] TICKS_BLANK   = 16'h0020;
    localparam logic [TMR_W-1:0] TICKS_SINGLE  = 16'h0009;
    localparam logic [TMR_W-1:0] TICKS_BURST   = 16'h0004;
    localparam logic [TMR_W-1:0] TICKS_SECTOR  = 16'h0100;
    localparam logic [TMR_W-1:0] TICKS_ARRAY   = 16'h0400;
    localparam logic [TMR_W-1:0] TICKS_ABORT   = 16'h0001;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_DATA = 3'b010,
        SEQ_CMD  = 3'b100
    } seq_e;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_req_s;

    function automatic logic cmd_legal(input logic [7:0] c);
        return c == CMD_BLANK_CHECK || c == CMD_SINGLE_PROGRAM || c == CMD_BURST_PROGRAM ||
               c == CMD_SECTOR_ERASE || c == CMD_ARRAY_ERASE || c == CMD_ERASE_ABORT;
    endfunction : cmd_legal

    function automatic logic cmd_prog_erase(input logic [7:0] c);
        return c == CMD_SINGLE_PROGRAM || c == CMD_BURST_PROGRAM ||
               c == CMD_SECTOR_ERASE || c == CMD_ARRAY_ERASE;
    endfunction : cmd_prog_erase
endpackage : mem_cmd_pkg

// ---- mem_tick_divider.sv ----
// Divider that turns the bus clock into memory clock tick pulses
`timescale 1ns/1ps
module mem_tick_divider
    import mem_cmd_pkg::*;
#(
    parameter int W = DIV_W
) (
    input  wire logic         hclk,    // Bus clock
    input  wire logic         hresetn, // Async reset, active low
    input  wire logic         run,     // Count only while a command runs
    input  wire logic [W-1:0] div,     // Divide ratio minus one
    output logic              tick     // One-cycle tick pulse
);
    logic [W-1:0] cnt;
    wire          wrap = (cnt >= div);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= (!run || wrap) ? '0 : cnt + 1'b1;
            tick <= run && wrap;
        end
    end
endmodule : mem_tick_divider

// ---- mem_op_timer.sv ----
// Timer that paces one running memory command
`timescale 1ns/1ps
module mem_op_timer
    import mem_cmd_pkg::*;
#(
    parameter int W = TMR_W
) (
    input  wire logic         hclk,    // Bus clock
    input  wire logic         hresetn, // Async reset, active low
    input  wire logic         load,    // Start a command
    input  wire logic [W-1:0] ticks,   // Length in ticks
    input  wire logic         tick,    // Divided clock pulse
    input  wire logic         kill,    // Abandon the command
    output logic              busy,    // Command running
    output logic              done     // One-cycle normal completion
);
    logic [W-1:0] left;
    wire          last = busy && tick && (left <= W'(1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left <= '0;
            busy <= 1'b0;
        end else if (kill) begin
            busy <= 1'b0;
        end else if (load) begin
            left <= ticks;
            busy <= 1'b1;
        end else if (last) begin
            busy <= 1'b0;
        end else if (busy && tick) begin
            left <= left - 1'b1;
        end
    end

    assign done = last && !kill;
endmodule : mem_op_timer

// ---- mem_cmd_status.sv ----
// Command and status logic of the program memory controller, AHB-Lite slave
`timescale 1ns/1ps
module mem_cmd_status
    import mem_cmd_pkg::*;
(
    input  wire logic        hclk,       // Bus clock
    input  wire logic        hresetn,    // Async reset, active low
    input  wire logic        hsel,       // Slave select
    input  wire logic [7:0]  haddr,      // Byte address
    input  wire logic [1:0]  htrans,     // Transfer type
    input  wire logic        hwrite,     // Write when high
    input  wire logic [2:0]  hsize,      // Transfer size
    input  wire logic [31:0] hwdata,     // Write data
    input  wire logic        hready,     // Bus ready
    output logic             hreadyout,  // Slave ready
    output logic             hresp,      // Always OKAY
    output logic [31:0]      hrdata,     // Read data
    input  wire logic        stop_req,   // Processor entering stop, pin
    input  wire logic        array_erased, // Array reads all ones, pin
    output logic             mem_busy,   // Command executing
    output logic [7:0]       mem_op,     // Code of last started command, held after it ends
    output logic [7:0]       mem_data,   // Latched data for the array
    output logic             irq         // Level interrupt
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ahb_req_s         req;
    logic             rd_wait;
    seq_e             seq;
    logic [7:0]       cmd_reg;
    logic [7:0]       act_code;
    logic [7:0]       buf_code;
    logic             buf_valid;
    logic             cbef;
    logic             ccf;
    logic             aerr;
    logic             blank;
    logic [DIV_W-1:0] div_val;
    logic             div_set;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic [1:0]       stop_s;
    logic             stop_d;
    logic [1:0]       erased_s;
    logic             tick;
    logic             tmr_busy;
    logic             tmr_done;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire addr_phase = hsel && htrans[1] && hready;
    wire wr_any     = req.valid && req.write;
    wire wr_status  = wr_any && req.addr == OFS_STATUS;
    wire wr_cmd     = wr_any && req.addr == OFS_COMMAND;
    wire wr_div     = wr_any && req.addr == OFS_DIVIDER;
    wire wr_data    = wr_any && req.addr == OFS_DATA;
    wire wr_istat   = wr_any && req.addr == OFS_INT_STATUS;
    wire wr_imask   = wr_any && req.addr == OFS_INT_MASK;
    wire [7:0] wb   = hwdata[7:0];

    // ----------------------------------------------------------------
    // Command sequence checks
    // ----------------------------------------------------------------
    wire launch_try = wr_status && wb[BIT_CBEF] && cbef;
    wire div_miss   = cmd_prog_erase(cmd_reg) && !div_set;
    wire launch_ok  = launch_try && seq == SEQ_CMD && !aerr && !div_miss;
    wire data_ok    = wr_data && seq == SEQ_IDLE && cbef;
    wire cmd_ok     = wr_cmd && seq == SEQ_DATA && cbef && cmd_legal(wb);
    wire seq_err    = (wr_data && !data_ok) || (wr_cmd && !cmd_ok) ||
                      (launch_try && !launch_ok);
    wire stop_rise  = stop_s[1] && !stop_d;
    wire stop_kill  = stop_rise && tmr_busy;
    wire aerr_set   = seq_err || stop_kill;

    // ----------------------------------------------------------------
    // Execution control
    // ----------------------------------------------------------------
    wire abort_kill = launch_ok && cmd_reg == CMD_ERASE_ABORT && tmr_busy &&
                      act_code == CMD_SECTOR_ERASE && !tmr_done;
    wire idle_now   = !tmr_busy || tmr_done;
    wire start_new  = launch_ok && idle_now && !abort_kill && !stop_kill;
    wire start_buf  = tmr_done && buf_valid && !stop_kill;
    wire start      = start_new || start_buf;
    wire [7:0] start_code = start_buf ? buf_code : cmd_reg;
    wire to_buf     = launch_ok && !idle_now && !abort_kill && !stop_kill;
    wire blank_set  = tmr_done && act_code == CMD_BLANK_CHECK;
    wire done_evt   = tmr_done || abort_kill;

    function automatic logic [TMR_W-1:0] op_ticks(input logic [7:0] c);
        case (c)
            CMD_BLANK_CHECK:    return TICKS_BLANK;
            CMD_SINGLE_PROGRAM: return TICKS_SINGLE;
            CMD_BURST_PROGRAM:  return TICKS_BURST;
            CMD_SECTOR_ERASE:   return TICKS_SECTOR;
            CMD_ARRAY_ERASE:    return TICKS_ARRAY;
            default:            return TICKS_ABORT;
        endcase
    endfunction : op_ticks

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    wire next_aerr  = aerr_set || (aerr && !(wr_status && wb[BIT_AERR]));
    wire next_blank = blank_set ? erased_s[1] : (blank && !launch_ok);
    wire next_buf   = to_buf || (buf_valid && !start_buf && !stop_kill);
    wire next_cbef  = !next_buf;
    wire next_busy  = start || (tmr_busy && !tmr_done && !abort_kill && !stop_kill);
    wire next_ccf   = !next_busy && !next_buf;
    wire [INT_W-1:0] int_evt = {aerr_set, done_evt};
    wire [INT_W-1:0] next_int = int_evt |
                                (int_status & ~(wr_istat ? wb[INT_W-1:0] : RST_INT));

    seq_e next_seq;
    always_comb begin
        next_seq = seq;
        case (seq)
            SEQ_IDLE: if (data_ok) begin
                next_seq = SEQ_DATA;
            end
            SEQ_DATA: if (cmd_ok) begin
                next_seq = SEQ_CMD;
            end
            SEQ_CMD: if (launch_ok) begin
                next_seq = SEQ_IDLE;
            end
            default: next_seq = SEQ_IDLE;
        endcase
        if (aerr_set) begin
            next_seq = SEQ_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire [7:0] status_rd = {cbef, ccf, 1'b0, aerr, 1'b0, blank, 2'b00};
    wire [7:0] rd_byte =
        req.addr == OFS_STATUS     ? status_rd :
        req.addr == OFS_COMMAND    ? cmd_reg :
        req.addr == OFS_DIVIDER    ? {div_set, div_val} :
        req.addr == OFS_DATA       ? mem_data :
        req.addr == OFS_INT_STATUS ? {6'h00, int_status} :
        req.addr == OFS_INT_MASK   ? {6'h00, int_mask} : 8'h00;

    // ----------------------------------------------------------------
    // Bus slave flops
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req       <= '0;
            rd_wait   <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            req       <= addr_phase ? ahb_req_s'{1'b1, hwrite, haddr} : ahb_req_s'('0);
            rd_wait   <= addr_phase && !hwrite;
            hreadyout <= !(addr_phase && !hwrite);
            hresp     <= 1'b0;
            if (rd_wait) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop_s   <= 2'b00;
            stop_d   <= 1'b0;
            erased_s <= 2'b00;
        end else begin
            stop_s   <= {stop_s[0], stop_req};
            stop_d   <= stop_s[1];
            erased_s <= {erased_s[0], array_erased};
        end
    end

    // ----------------------------------------------------------------
    // Command and status registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq        <= SEQ_IDLE;
            aerr       <= 1'b0;
            blank      <= 1'b0;
            cbef       <= 1'b1;
            ccf        <= 1'b1;
            buf_valid  <= 1'b0;
            int_status <= RST_INT;
        end else begin
            seq        <= next_seq;
            aerr       <= next_aerr;
            blank      <= next_blank;
            cbef       <= next_cbef;
            ccf        <= next_ccf;
            buf_valid  <= next_buf;
            int_status <= next_int;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_reg  <= RST_BYTE;
            mem_data <= RST_BYTE;
            div_val  <= RST_DIVIDER;
            div_set  <= 1'b0;
            int_mask <= RST_INT;
        end else begin
            if (cmd_ok) begin
                cmd_reg <= wb;
            end
            if (data_ok) begin
                mem_data <= wb;
            end
            if (wr_div && !tmr_busy) begin
                div_val <= wb[DIV_W-1:0];
                div_set <= 1'b1;
            end
            if (wr_imask) begin
                int_mask <= wb[INT_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_code <= RST_BYTE;
            buf_code <= RST_BYTE;
            mem_busy <= 1'b0;
            mem_op   <= RST_BYTE;
            irq      <= 1'b0;
        end else begin
            if (start) begin
                act_code <= start_code;
            end
            if (to_buf) begin
                buf_code <= cmd_reg;
            end
            mem_busy <= next_busy;
            mem_op   <= start ? start_code : mem_op;
            irq      <= |(next_int & int_mask);
        end
    end

    // ----------------------------------------------------------------
    // Memory clock and command timer
    // ----------------------------------------------------------------
    mem_tick_divider #(.W(DIV_W)) u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (tmr_busy),
        .div     (div_val),
        .tick    (tick)
    );

    mem_op_timer #(.W(TMR_W)) u_tmr (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (start),
        .ticks   (op_ticks(start_code)),
        .tick    (tick),
        .kill    (stop_kill || abort_kill),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_seq_order: assert property (wr_cmd && seq == SEQ_IDLE |=> aerr)
        else $error("command write out of order kept");
    chk_div_first: assert property (launch_try && seq == SEQ_CMD && div_miss |=> aerr && !mem_busy[*2])
        else $error("launch without divider not flagged");
    chk_stop_error: assert property (stop_kill |=> aerr && !tmr_busy)
        else $error("stop during command not flagged");
    chk_aerr_clear: assert property (aerr && wr_status && wb[BIT_AERR] && !aerr_set |=> !aerr)
        else $error("write one did not clear error");
    chk_aerr_keep: assert property (aerr && !(wr_status && wb[BIT_AERR]) |=> aerr)
        else $error("error flag lost");
    chk_blank_result: assert property (blank_set |=> blank == $past(erased_s[1]))
        else $error("blank flag wrong after blank check");
    chk_blank_launch: assert property (launch_ok && !blank_set |=> !blank)
        else $error("blank flag kept over launch");
    chk_blank_stable: assert property (blank && ccf && !launch_ok |=> blank)
        else $error("blank flag dropped while complete");
    chk_legal_codes: assert property (wr_cmd && cmd_legal(wb) && seq == SEQ_DATA && cbef
        |=> cmd_reg == $past(wb))
        else $error("legal command not stored");
    chk_illegal_code: assert property (wr_cmd && !cmd_legal(wb) |=> aerr && seq == SEQ_IDLE)
        else $error("illegal command not flagged");
    chk_abort_erase: assert property (abort_kill |=> !tmr_busy ##1 !mem_busy)
        else $error("abort did not end sector erase");
    chk_ccf_busy: assert property (start |=> !ccf && mem_busy)
        else $error("complete set while command runs");

    cov_blank_pass: cover property (blank_set && erased_s[1]);
    cov_buffered: cover property (to_buf ##[1:1000] start_buf);
    cov_abort: cover property (abort_kill);
    cov_stop: cover property (stop_kill);
endmodule : mem_cmd_status

// ---- tb_top.sv ----
// Self-checking testbench of the memory command and status logic
`timescale 1ns/1ps
module tb_top;
    import mem_cmd_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        stop_req;
    logic        array_erased;
    logic        mem_busy;
    logic [7:0]  mem_op;
    logic [7:0]  mem_data;
    logic        irq;
    logic [31:0] rd;
    logic [7:0]  codes [6];
    int          fail_count;
    int          samples_checked;

    assign hready = hreadyout;

    mem_cmd_status i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .stop_req(stop_req), .array_erased(array_erased), .mem_busy(mem_busy),
        .mem_op(mem_op), .mem_data(mem_data), .irq(irq)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------------------------------
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task check(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            fail_count++;
            summarize();
        end
    endtask : wait_ready

    task ahb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_ready();
        rd = hrdata;
    endtask : ahb

    task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 8'h00);
        check(name, rd, exp);
    endtask : rchk

    task launch(input logic [7:0] code);
        ahb(1'b1, OFS_DATA, 8'h5a);
        ahb(1'b1, OFS_COMMAND, code);
        ahb(1'b1, OFS_STATUS, 8'h80);
    endtask : launch

    task clr;
        ahb(1'b1, OFS_STATUS, 8'h10);
        ahb(1'b1, OFS_INT_STATUS, 8'h03);
    endtask : clr

    task wait_done;
        int n;
        n = 0;
        repeat (3) @(posedge hclk);
        while (mem_busy !== 1'b0 && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        if (mem_busy !== 1'b0) begin
            fail_count++;
            summarize();
        end
    endtask : wait_done

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        hresetn      = 1'b0;
        hsel         = 1'b0;
        haddr        = 8'h00;
        htrans       = 2'b00;
        hwrite       = 1'b0;
        hsize        = 3'b010;
        hwdata       = 32'h0;
        stop_req     = 1'b0;
        array_erased = 1'b1;
        fail_count   = 0;
        samples_checked = 0;
        codes = '{CMD_BLANK_CHECK, CMD_SINGLE_PROGRAM, CMD_BURST_PROGRAM,
                  CMD_SECTOR_ERASE, CMD_ARRAY_ERASE, CMD_ERASE_ABORT};
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk("status reset", OFS_STATUS, 32'hc0);
        launch(8'h33);
        rchk("status illegal", OFS_STATUS, 32'hd0);
        check("data latch", {24'h0, mem_data}, 32'h5a);
        ahb(1'b1, OFS_STATUS, 8'h00);
        rchk("status zero write", OFS_STATUS, 32'hd0);
        ahb(1'b1, OFS_INT_MASK, 8'h02);
        // Mask lands at the end of the data phase, irq follows one cycle later
        repeat (2) @(posedge hclk);
        check("irq error", {31'h0, irq}, 32'h1);
        clr();
        rchk("status cleared", OFS_STATUS, 32'hc0);
        check("irq cleared", {31'h0, irq}, 32'h0);
        ahb(1'b1, OFS_COMMAND, CMD_SINGLE_PROGRAM);
        rchk("status order", OFS_STATUS, 32'hd0);
        clr();
        launch(CMD_SINGLE_PROGRAM);
        rchk("status no divider", OFS_STATUS, 32'hd0);
        check("busy no divider", {31'h0, mem_busy}, 32'h0);
        clr();
        ahb(1'b1, OFS_DIVIDER, 8'h00);
        rchk("divider", OFS_DIVIDER, 32'h80);
        for (int i = 0; i < 6; i++) begin
            launch(codes[i]);
            wait_done();
            check("running code", {24'h0, mem_op}, {24'h0, codes[i]});
            rchk("status after cmd", OFS_STATUS, (i == 0) ? 32'hc4 : 32'hc0);
        end
        array_erased <= 1'b0;
        launch(CMD_BLANK_CHECK);
        wait_done();
        rchk("blank not erased", OFS_STATUS, 32'hc0);
        array_erased <= 1'b1;
        launch(CMD_BLANK_CHECK);
        wait_done();
        ahb(1'b1, OFS_STATUS, 8'h04);
        rchk("blank direct write", OFS_STATUS, 32'hc4);
        // Second launch while an erase runs goes to the buffer
        launch(CMD_SECTOR_ERASE);
        launch(CMD_SINGLE_PROGRAM);
        rchk("status buffered", OFS_STATUS, 32'h00);
        wait_done();
        check("buffered code", {24'h0, mem_op}, {24'h0, CMD_SINGLE_PROGRAM});
        rchk("status both done", OFS_STATUS, 32'hc0);
        // Abort ends a running sector erase and flags done
        clr();
        launch(CMD_SECTOR_ERASE);
        launch(CMD_ERASE_ABORT);
        rchk("status aborted", OFS_STATUS, 32'hc0);
        check("busy aborted", {31'h0, mem_busy}, 32'h0);
        check("code aborted", {24'h0, mem_op}, {24'h0, CMD_SECTOR_ERASE});
        rchk("int aborted", OFS_INT_STATUS, 32'h01);
        launch(CMD_SECTOR_ERASE);
        repeat (5) @(posedge hclk);
        rchk("status running", OFS_STATUS, 32'h80);
        stop_req <= 1'b1;
        repeat (8) @(posedge hclk);
        check("busy after stop", {31'h0, mem_busy}, 32'h0);
        rchk("status stop", OFS_STATUS, 32'hd0);
        check("irq stop", {31'h0, irq}, 32'h1);
        stop_req <= 1'b0;
        clr();
        rchk("unmapped", 8'h20, 32'h0);
        check("hresp okay", {31'h0, hresp}, 32'h0);
        summarize();
    end
endmodule : tb_top
